// File: dv/ecc_irq_monitor.sv
`timescale 1ns/1ps
`include "ecc_irq_defines.vh"
module ecc_irq_monitor (
  input wire clk,
  input wire sys_rst,
  input wire hwRstN,
  input wire swRst,
  input wire csSigRst,
  input wire cmdValid,
  input wire [2:0] cmdCode,
  input wire cmdOverlay,
  input wire [15:0] cmdWrData,
  input wire unitCheckDone,
  input wire fetchReq,
  input wire [31:0] fetchAddr,
  input wire [15:0] rdData,
  input wire rdValid,
  input wire [15:0] ecc_error_count_reg,
  input wire intOe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire quiet = !cmdValid && !swRst && !csSigRst && hwRstN;
  wire isRd = cmdValid && (cmdCode == 3'h2 || cmdCode == 3'h3 || cmdCode == 3'h7
    || (cmdCode == 3'h1 && cmdOverlay));
  sequence clrCmd;
    cmdValid && cmdCode == 3'h6 && cmdOverlay;
  endsequence
  sequence cntRd;
    cmdValid && cmdCode == 3'h1 && cmdOverlay && !unitCheckDone;
  endsequence
  // ==========
  // Counter
  count_step_a:
    assert property (ecc_error_count_reg == $past(ecc_error_count_reg)
      || ecc_error_count_reg == $past(ecc_error_count_reg) + 16'h1
      || ecc_error_count_reg == 16'h0) else $error("counter jumped");
  count_hold_a:
    assert property (quiet && !unitCheckDone |=> $stable(ecc_error_count_reg))
      else $error("counter moved without cause");
  count_sat_a:
    assert property (quiet && ecc_error_count_reg == 16'hFFFF
      |=> ecc_error_count_reg == 16'hFFFF) else $error("counter left saturation");
  ecc_clear_a:
    assert property (clrCmd |=> ecc_error_count_reg == 16'h0) else $error("clear missed");
  soft_rst_a:
    assert property (swRst || csSigRst |=> ecc_error_count_reg == 16'h0 && !intOe)
      else $error("reset pulse missed");
  // ==========
  // Reads and interrupt
  rd_answer_a:
    assert property (isRd |=> rdValid) else $error("read not answered");
  rd_none_a:
    assert property (!isRd |=> !rdValid) else $error("spurious answer");
  rd_count_a:
    assert property (cntRd |=> rdData == $past(ecc_error_count_reg))
      else $error("count read wrong");
  irq_off_a:
    assert property (cmdValid && cmdCode == 3'h4 && cmdWrData[15] |=> !intOe)
      else $error("disable ignored");
  fetch_align_a:
    assert property (fetchReq |-> fetchAddr[3:0] == 4'h0) else $error("fetch unaligned");
endmodule // ecc_irq_monitor

bind ecc_error_counter_and_irq ecc_irq_monitor mon (.clk(clk), .sys_rst(sys_rst),
  .hwRstN(hwRstN), .swRst(swRst), .csSigRst(csSigRst), .cmdValid(cmdValid),
  .cmdCode(cmdCode), .cmdOverlay(cmdOverlay), .cmdWrData(cmdWrData),
  .unitCheckDone(unitCheckDone), .fetchReq(fetchReq), .fetchAddr(fetchAddr),
  .rdData(rdData), .rdValid(rdValid), .ecc_error_count_reg(ecc_error_count_reg),
  .intOe(intOe));

// File: dv/host_link.sv
`timescale 1ns/1ps
module host_link (
  input wire frameOn,
  output wire csN,
  output reg linkClk
);
  assign csN = !frameOn;
  initial linkClk = 1'b0;
  // Link clock stands still between frames, as a real host does
  always #80 linkClk = frameOn ? ~linkClk : 1'b0;
endmodule // host_link

// File: dv/test_ecc_error_counter_and_irq.sv
`timescale 1ns/1ps
`include "ecc_irq_defines.vh"
module test_ecc_error_counter_and_irq;
  reg clk = 1'b0, sys_rst = 1'b1, hwRstN = 1'b1, swRst = 1'b0, csSigRst = 1'b0;
  reg cmdValid = 1'b0, cmdOverlay = 1'b0, frameOn = 1'b0, devBusy = 1'b0;
  reg [2:0] cmdCode = 3'h0;
  reg [15:0] cmdWrData = 16'h0;
  reg [31:0] cmdAddr = 32'h0;
  reg [7:0] volatileConfigFour = 8'h08;
  reg unitCheckDone = 1'b0, unitErr1 = 1'b0, unitErr2 = 1'b0;
  reg unitMainArray = 1'b0, unitMultiProg = 1'b0;
  wire csN, linkClk, fetchReq, rdValid, intOut, intOe;
  wire [31:0] fetchAddr;
  wire [15:0] rdData, cnt;
  int err_total = 0, n_checks = 0;
  always #10 clk = ~clk;
  host_link LINK (.frameOn(frameOn), .csN(csN), .linkClk(linkClk));
  ecc_error_counter_and_irq #(.BEATS(2)) DUT (.clk(clk), .sys_rst(sys_rst), .csN(csN),
    .linkClk(linkClk), .hwRstN(hwRstN), .swRst(swRst), .csSigRst(csSigRst),
    .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdOverlay(cmdOverlay),
    .cmdWrData(cmdWrData), .cmdAddr(cmdAddr), .volatileConfigFour(volatileConfigFour),
    .unitCheckDone(unitCheckDone), .unitErr1(unitErr1), .unitErr2(unitErr2),
    .unitMainArray(unitMainArray), .unitMultiProg(unitMultiProg), .devBusy(devBusy),
    .fetchReq(fetchReq), .fetchAddr(fetchAddr), .rdData(rdData), .rdValid(rdValid),
    .ecc_error_count_reg(cnt), .intOut(intOut), .intOe(intOe));
  task chk(input string nm, input [31:0] got, input [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task cmd(input [2:0] c, input ov, input [15:0] d);
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdCode <= c;
    cmdOverlay <= ov;
    cmdWrData <= d;
    @(posedge clk);
    cmdValid <= 1'b0;
    #1;
  endtask
  task unit(input e1, e2, mn, mp);
    @(posedge clk);
    unitCheckDone <= 1'b1;
    unitErr1 <= e1;
    unitErr2 <= e2;
    unitMainArray <= mn;
    unitMultiProg <= mp;
    @(posedge clk);
    unitCheckDone <= 1'b0;
    #1;
  endtask
  task openRd(input [31:0] a);
    frameOn <= 1'b1;
    cmdAddr <= a;
    repeat (8) @(posedge clk);
    cmd(3'h0, 1'b0, 16'h0);
  endtask
  task closeRd;
    frameOn <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  initial
  begin
    #1800000;
    err_total++;
    conclude;
  end
  initial
  begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    cmd(3'h1, 1'b1, 16'h0);
    chk("count", rdData, 16'h0);
    cmd(3'h2, 1'b0, 16'h0);
    chk("config", rdData, 16'h8000);
    cmd(3'h1, 1'b0, 16'h0);
    chk("refused", rdValid, 1'h0);
    $display("reset test done");
    openRd(32'h123);
    chk("fetchReq", fetchReq, 1'h1);
    chk("fetch", fetchAddr, 32'h120);
    unit(1, 0, 1, 0);
    chk("count", cnt, 16'h1);
    unit(0, 1, 1, 0);
    chk("count", cnt, 16'h2);
    unit(1, 0, 0, 0);
    chk("count", cnt, 16'h2);
    cmd(3'h7, 1'b0, 16'h0);
    chk("count", cnt, 16'h2);
    volatileConfigFour <= 8'h00;
    unit(0, 1, 1, 0);
    chk("count", cnt, 16'h2);
    unit(1, 0, 1, 1);
    chk("count", cnt, 16'h2);
    closeRd;
    unit(1, 0, 1, 0);
    chk("count", cnt, 16'h2);
    openRd(32'h120);
    unit(1, 0, 1, 0);
    chk("count", cnt, 16'h3);
    cmd(3'h6, 1'b0, 16'h0);
    chk("count", cnt, 16'h3);
    $display("count test done");
    cmd(3'h4, 1'b0, 16'h0003);
    unit(1, 0, 1, 0);
    chk("irq", intOe, 1'h1);
    chk("pin", intOut, 1'h0);
    cmd(3'h3, 1'b0, 16'h0);
    chk("status", rdData, 16'h0001);
    cmd(3'h5, 1'b0, 16'h0001);
    chk("irq", intOe, 1'h0);
    volatileConfigFour <= 8'h08;
    unit(1, 0, 1, 0);
    unit(0, 1, 1, 0);
    cmd(3'h5, 1'b0, 16'h0001);
    chk("irq", intOe, 1'h1);
    cmd(3'h6, 1'b1, 16'h0);
    chk("irq", intOe, 1'h0);
    chk("count", cnt, 16'h0);
    cmd(3'h2, 1'b0, 16'h0);
    chk("config", rdData, 16'h0003);
    cmd(3'h4, 1'b0, 16'h0004);
    devBusy <= 1'b1;
    repeat (3) @(posedge clk);
    devBusy <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("irq", intOe, 1'h1);
    cmd(3'h3, 1'b0, 16'h0);
    chk("status", rdData, 16'h0004);
    cmd(3'h4, 1'b0, 16'h8004);
    chk("irq", intOe, 1'h0);
    cmd(3'h4, 1'b0, 16'h0000);
    unit(1, 0, 1, 0);
    chk("irq", intOe, 1'h0);
    cmd(3'h4, 1'b0, 16'h0003);
    unit(1, 0, 1, 0);
    csSigRst <= 1'b1;
    @(posedge clk);
    csSigRst <= 1'b0;
    #1 chk("irq", intOe, 1'h0);
    chk("count", cnt, 16'h0);
    // hardware reset restores the default config
    hwRstN <= 1'b0;
    repeat (6) @(posedge clk);
    hwRstN <= 1'b1;
    repeat (5) @(posedge clk);
    cmd(3'h2, 1'b0, 16'h0);
    chk("config", rdData, 16'h8000);
    closeRd;
    openRd(32'h0);
    unit(1, 0, 1, 0);
    chk("count", cnt, 16'h1);
    swRst <= 1'b1;
    @(posedge clk);
    swRst <= 1'b0;
    #1 chk("count", cnt, 16'h0);
    $display("irq test done");
    closeRd;
    openRd(32'h0);
    @(posedge clk);
    unitCheckDone <= 1'b1;
    repeat (65540) @(posedge clk);
    unitCheckDone <= 1'b0;
    #1 chk("count", cnt, 16'hFFFF);
    $display("saturation test done");
    conclude;
  end
endmodule // test_ecc_error_counter_and_irq

// File: hdl/ecc_error_counter_and_irq.v
`timescale 1ns/1ps
`include "ecc_irq_defines.vh"

// Overview of operation
// (RULE1) 16-bit counter of 1-bit/2-bit read errors
// (RULE2) Count only main array errors
// (RULE3) Count only in array reads; status read untouched
// (RULE4) Counter saturates at all ones
// (RULE5) Burst reads keep fetching and counting until CS high
// (RULE6) One count per errored unit per transaction
// (RULE7) Multi-programmed unit without double detect: ignore
// (RULE8) Counter zeroed by all resets and clear
// (RULE9) Events: double error, single error, ready
// (RULE10) Config enables output and selects events
// (RULE11) Status records enabled events until cleared
// (RULE12) Host ignores event output during resets
// (RULE13) Config bit 15 set releases the output
// (RULE14) Write one clears status; all must clear
// (RULE15) Overlay clear drops ECC status, keeps enables
// (RULE16) Signalling, hardware, power-on reset release output
// (RULE17) Hardware and power-on reset restore config
// (RULE18) Double detect only with config four bit 3
// (RULE19) Errors belong to aligned 16-byte units
// (RULE20) Ready flag sits at status bit 2
// (RULE21) Count and flag in check-done cycle
module ecc_error_counter_and_irq #(
  parameter BEATS = `BEATS_PER_UNIT
) (
  input wire clk,
  input wire sys_rst,
  input wire csN,
  input wire linkClk,
  input wire hwRstN,
  input wire swRst,
  input wire csSigRst,
  input wire cmdValid,
  input wire [`CMD_W-1:0] cmdCode,
  input wire cmdOverlay,
  input wire [`REG_W-1:0] cmdWrData,
  input wire [`ADDR_W-1:0] cmdAddr,
  input wire [7:0] volatileConfigFour,
  input wire unitCheckDone,
  input wire unitErr1,
  input wire unitErr2,
  input wire unitMainArray,
  input wire unitMultiProg,
  input wire devBusy,
  output reg fetchReq,
  output reg [`ADDR_W-1:0] fetchAddr,
  output reg [`REG_W-1:0] rdData,
  output reg rdValid,
  output wire [`REG_W-1:0] ecc_error_count_reg,
  output wire intOut,
  output reg intOe
);
  localparam BEAT_W = 8;
  localparam [BEAT_W-1:0] BEAT_LAST = BEATS - 1;

  // ==================================================
  // Pin synchronisers
  wire csLevel;
  wire csRise;
  wire csFall;
  wire linkRise;
  wire hwRstLevelN;

  pin_sync #(
    .RESET_VAL(1'b1)
  ) u_cs_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pinIn(csN),
    .level(csLevel),
    .rise(csRise),
    .fall(csFall)
  );

  pin_sync #(
    .RESET_VAL(1'b0)
  ) u_link_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pinIn(linkClk),
    .level(),
    .rise(linkRise),
    .fall()
  );

  pin_sync #(
    .RESET_VAL(1'b1)
  ) u_hwrst_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pinIn(hwRstN),
    .level(hwRstLevelN),
    .rise(),
    .fall()
  );

  // ==================================================
  // Reset classes
  wire hwReset;
  wire cfgReset;
  wire softReset;

  // (RULE17) power-on and hardware reset
  assign hwReset = ~hwRstLevelN;
  assign cfgReset = sys_rst | hwReset;
  // (RULE16) reset classes that release output
  assign softReset = cfgReset | csSigRst | swRst;

  // ==================================================
  // Command decode
  reg csFallSeen_reg;
  wire cmdArrayRead;
  wire cmdClearEcc;
  wire cmdProgCfg;
  wire cmdProgStat;

  // A read needs a fresh frame, so a stale command after CS rise is refused
  always @(posedge clk)
  begin
    if (sys_rst || csRise)
      csFallSeen_reg <= 1'b0;
    else if (csFall)
      csFallSeen_reg <= 1'b1;
  end

  assign cmdArrayRead = cmdValid && cmdCode == `CMD_ARRAY_READ && !csLevel
                        && csFallSeen_reg;
  // (RULE15) clear only inside overlay space
  assign cmdClearEcc = cmdValid && cmdCode == `CMD_CLEAR_ECC && cmdOverlay;
  assign cmdProgCfg = cmdValid && cmdCode == `CMD_PROGRAM_IRQ_CONFIG;
  assign cmdProgStat = cmdValid && cmdCode == `CMD_PROGRAM_IRQ_STATUS;

  // ==================================================
  // Array read sequencing
  reg readActive_reg;
  reg [BEAT_W-1:0] beatCount_reg;
  reg [`ADDR_W-1:0] unitAddr_reg;
  reg readActive_next;
  reg [BEAT_W-1:0] beatCount_next;
  reg [`ADDR_W-1:0] unitAddr_next;
  reg fetchReq_next;

  // Unit address is word-aligned to 16 bytes
  wire [`ADDR_W-1:0] alignedStart;
  // (RULE19) align to the data unit
  assign alignedStart = cmdAddr & ~(`UNIT_BYTES - 32'h00000001);

  always @*
  begin
    readActive_next = readActive_reg;
    beatCount_next = beatCount_reg;
    unitAddr_next = unitAddr_reg;
    fetchReq_next = 1'b0;
    if (softReset || csRise)
    begin
      readActive_next = 1'b0;
      beatCount_next = {BEAT_W{1'b0}};
    end
    else if (cmdArrayRead)
    begin
      readActive_next = 1'b1;
      beatCount_next = {BEAT_W{1'b0}};
      unitAddr_next = alignedStart;
      fetchReq_next = 1'b1;
    end
    else if (readActive_reg && linkRise)
    begin
      // (RULE5) next sequential unit each unit of beats
      if (beatCount_reg == BEAT_LAST)
      begin
        beatCount_next = {BEAT_W{1'b0}};
        unitAddr_next = unitAddr_reg + `UNIT_BYTES;
        fetchReq_next = 1'b1;
      end
      else
        beatCount_next = beatCount_reg + {{(BEAT_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      readActive_reg <= 1'b0;
      beatCount_reg <= {BEAT_W{1'b0}};
      unitAddr_reg <= {`ADDR_W{1'b0}};
      fetchReq <= 1'b0;
      fetchAddr <= {`ADDR_W{1'b0}};
    end
    else
    begin
      readActive_reg <= readActive_next;
      beatCount_reg <= beatCount_next;
      unitAddr_reg <= unitAddr_next;
      fetchReq <= fetchReq_next;
      fetchAddr <= unitAddr_next;
    end
  end

  // ==================================================
  // Error qualification
  wire doubleEnable;
  wire unitIgnored;
  wire errSingle;
  wire errDouble;
  wire countInc;

  // (RULE18) double detect gated by config four
  assign doubleEnable = volatileConfigFour[`CFG4_DOUBLE_EN];
  // (RULE7) no detection in a re-programmed unit unless double detect is on
  assign unitIgnored = unitMultiProg && !doubleEnable;
  // (RULE3) only inside an array read
  assign errSingle = unitCheckDone && readActive_reg && !unitIgnored && unitErr1;
  assign errDouble = unitCheckDone && readActive_reg && !unitIgnored
                     && doubleEnable && unitErr2;
  // (RULE2) main array errors only
  // (RULE6) one check-done pulse per fetched unit
  assign countInc = (errSingle || errDouble) && unitMainArray;

  // ==================================================
  // Error counter
  // (RULE8) all resets and clear zero the counter
  wire countClear;
  assign countClear = softReset | cmdClearEcc;

  // (RULE1) counter kept in its own module
  // (RULE21) increments in the check-done cycle
  sat_counter #(
    .W(`REG_W)
  ) u_count (
    .clk(clk),
    .clear(countClear),
    .inc(countInc),
    .count_reg(ecc_error_count_reg)
  );

  // ==================================================
  // Last-unit ECC status
  reg [`REG_W-1:0] eccStatus_reg;

  always @(posedge clk)
  begin
    if (softReset || cmdClearEcc)
      eccStatus_reg <= `IRQ_STATUS_RESET;
    else if (unitCheckDone && readActive_reg)
    begin
      eccStatus_reg <= `IRQ_STATUS_RESET;
      eccStatus_reg[`ECC_STAT_SINGLE] <= errSingle;
      eccStatus_reg[`ECC_STAT_DOUBLE] <= errDouble;
    end
  end

  // ==================================================
  // Interrupt events
  reg busyDelay_reg;
  wire readyEvent;
  wire [`REG_W-1:0] eventVec;

  always @(posedge clk)
  begin
    if (sys_rst)
      busyDelay_reg <= 1'b0;
    else
      busyDelay_reg <= devBusy;
  end

  assign readyEvent = busyDelay_reg && !devBusy;

  // (RULE9) three event sources
  // (RULE20) ready event on status bit 2
  assign eventVec = {13'h0000, readyEvent, errDouble, errSingle};

  // ==================================================
  // Interrupt configuration and status
  reg [`REG_W-1:0] irqConfig_reg;
  reg [`REG_W-1:0] irqStatus_reg;
  reg [`REG_W-1:0] irqStatus_next;
  reg [`REG_W-1:0] clearMask;
  wire [`REG_W-1:0] setMask;
  wire [`REG_W-1:0] irqConfig_next;

  always @(posedge clk)
  begin
    // (RULE17) restore all-disabled default
    if (cfgReset)
      irqConfig_reg <= `IRQ_CONFIG_RESET;
    else if (cmdProgCfg)
      irqConfig_reg <= cmdWrData;
  end

  // The pin follows a config write in the same edge, not one cycle late
  assign irqConfig_next = cmdProgCfg ? cmdWrData : irqConfig_reg;

  // (RULE11) only enabled events are recorded
  assign setMask = eventVec & irqConfig_reg & `IRQ_EVENT_MASK;

  always @*
  begin
    clearMask = {`REG_W{1'b0}};
    // (RULE14) write one to clear
    if (cmdProgStat)
      clearMask = cmdWrData;
    // (RULE15) clear ECC flags, enables untouched
    if (cmdClearEcc)
      clearMask = clearMask | `IRQ_ECC_MASK;
    // A new event in the clearing cycle survives
    irqStatus_next = ((irqStatus_reg & ~clearMask) | setMask) & `IRQ_EVENT_MASK;
  end

  always @(posedge clk)
  begin
    if (softReset)
      irqStatus_reg <= `IRQ_STATUS_RESET;
    else
      irqStatus_reg <= irqStatus_next;
  end

  // ==================================================
  // Event output, open drain
  wire outEnabled;
  wire pending;

  // (RULE13) bit 15 set disables and releases
  assign outEnabled = !irqConfig_next[`IRQ_BIT_DISABLE];
  // (RULE14) low while any enabled flag stands
  assign pending = |(irqStatus_next & irqConfig_next);

  // Only ever drives low; the pull-up gives the high level
  assign intOut = 1'b0;

  always @(posedge clk)
  begin
    // (RULE16) resets float the pin
    if (softReset)
      intOe <= 1'b0;
    // (RULE10) drive low only on enabled event
    else
      intOe <= outEnabled && pending;
  end

  // ==================================================
  // Register read-back
  reg [`REG_W-1:0] rdData_next;
  reg rdValid_next;

  always @*
  begin
    rdData_next = rdData;
    rdValid_next = 1'b0;
    if (cmdValid)
    begin
      if (cmdCode == `CMD_READ_COUNT && cmdOverlay)
      begin
        rdData_next = ecc_error_count_reg;
        rdValid_next = 1'b1;
      end
      else if (cmdCode == `CMD_READ_IRQ_CONFIG)
      begin
        rdData_next = irqConfig_reg;
        rdValid_next = 1'b1;
      end
      else if (cmdCode == `CMD_READ_IRQ_STATUS)
      begin
        rdData_next = irqStatus_reg;
        rdValid_next = 1'b1;
      end
      // (RULE3) status read leaves the counter alone
      else if (cmdCode == `CMD_READ_ECC_STATUS)
      begin
        rdData_next = eccStatus_reg;
        rdValid_next = 1'b1;
      end
    end
  end

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      rdData <= {`REG_W{1'b0}};
      rdValid <= 1'b0;
    end
    else
    begin
      rdData <= rdData_next;
      rdValid <= rdValid_next;
    end
  end

endmodule // ecc_error_counter_and_irq

// File: hdl/ecc_irq_defines.vh
`ifndef ECC_IRQ_DEFINES_VH
`define ECC_IRQ_DEFINES_VH

// ==================================================
// Transaction codes seen on cmdCode
`define CMD_W 3
`define CMD_ARRAY_READ 3'h0
`define CMD_READ_COUNT 3'h1
`define CMD_READ_IRQ_CONFIG 3'h2
`define CMD_READ_IRQ_STATUS 3'h3
`define CMD_PROGRAM_IRQ_CONFIG 3'h4
`define CMD_PROGRAM_IRQ_STATUS 3'h5
`define CMD_CLEAR_ECC 3'h6
`define CMD_READ_ECC_STATUS 3'h7

// ==================================================
// Register widths and reset values
`define REG_W 16
`define COUNT_RESET 16'h0000
`define COUNT_SATURATE 16'hFFFF
`define IRQ_CONFIG_RESET 16'h8000
`define IRQ_STATUS_RESET 16'h0000

// ==================================================
// Field positions, shared by config enables and status flags
`define IRQ_BIT_ECC1 0
`define IRQ_BIT_ECC2 1
`define IRQ_BIT_READY 2
`define IRQ_BIT_DISABLE 15
`define IRQ_EVENT_MASK 16'h0007
`define IRQ_ECC_MASK 16'h0003

// ==================================================
// Per-unit ECC status layout and config four double-detect bit
`define ECC_STAT_SINGLE 1
`define ECC_STAT_DOUBLE 3
`define CFG4_DOUBLE_EN 3

// ==================================================
// Data unit geometry and link timing
`define ADDR_W 32
`define UNIT_BYTES 32'h00000010
`define BEATS_PER_UNIT 8

`endif

// File: hdl/pin_sync.v
`timescale 1ns/1ps
`include "ecc_irq_defines.vh"

// ==================================================
// Three-stage synchroniser with agreement filter
module pin_sync #(
  parameter RESET_VAL = 1'b1
) (
  input wire clk,
  input wire sys_rst,
  input wire pinIn,
  output reg level,
  output reg rise,
  output reg fall
);
  reg stage1;
  reg stage2;
  reg stage3;

  // Stage1 feeds only stage2; the level moves once stages 2 and 3 agree
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      stage1 <= RESET_VAL;
      stage2 <= RESET_VAL;
      stage3 <= RESET_VAL;
      level <= RESET_VAL;
      rise <= 1'b0;
      fall <= 1'b0;
    end
    else
    begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
      rise <= 1'b0;
      fall <= 1'b0;
      if (stage2 == stage3 && stage3 != level)
      begin
        level <= stage3;
        rise <= stage3;
        fall <= ~stage3;
      end
    end
  end
endmodule // pin_sync

// File: hdl/sat_counter.v
`timescale 1ns/1ps
`include "ecc_irq_defines.vh"

// ==================================================
// Saturating up-counter with clear
module sat_counter #(
  parameter W = 16
) (
  input wire clk,
  input wire clear,
  input wire inc,
  output reg [W-1:0] count_reg
);
  reg [W-1:0] count_next;

  always @*
  begin
    count_next = count_reg;
    if (clear)
      count_next = {W{1'b0}};
    // (RULE4) stop at all ones
    else if (inc && count_reg != {W{1'b1}})
      count_next = count_reg + {{(W-1){1'b0}}, 1'b1};
  end

  always @(posedge clk)
  begin
    count_reg <= count_next;
  end
endmodule // sat_counter
